// ===== pkg/key_link_defines.svh
// Constants shared by both ends of the serial key and display link.
// Assumes a 100 MHz system clock on the controller side.
`ifndef KEY_LINK_DEFINES_SVH
`define KEY_LINK_DEFINES_SVH

// ****************************************************************
// Frame layout
// ****************************************************************
`define ADDR_BITS 8
`define KEY_READ_ADDR 8'h43
`define DISP_ADDR_A 8'h41
`define DISP_ADDR_B 8'h42
`define KEY_BITS 30
`define READ_BITS 31
`define DISP_BITS 75
`define DISP_HALF 38
`define READ_LAST_EDGE (`ADDR_BITS + `READ_BITS - 1)
`define DISP_LAST_EDGE (`ADDR_BITS + `DISP_HALF - 1)

// ****************************************************************
// Timing
// ****************************************************************
`define SCAN_AGREED_T 615
`define SCAN_RESCAN_T 1230
`define CLK_NS 10
`define CLK_MHZ 100
`define DEV_OSC_MAX_NS 10
`define HALF_BIT_CYCLES 8
`define DISP_WINDOW_MS 30
`define DISP_WINDOW_CYCLES (`DISP_WINDOW_MS * 1000 * `CLK_MHZ)
`define RESCAN_HOST_CYCLES \
  ((`SCAN_RESCAN_T * `DEV_OSC_MAX_NS + `CLK_NS - 1) / `CLK_NS)
`define HOLDOFF_CYCLES (`RESCAN_HOST_CYCLES + 16)
`define POLL_CYCLES (`RESCAN_HOST_CYCLES + \
  (`ADDR_BITS + `READ_BITS + 2) * 2 * `HALF_BIT_CYCLES + 16)

`endif

// ===== pkg/key_link_pkg.sv
// Types shared by both ends of the serial key and display link.
// Assumes key_link_defines.svh for all figures.
package key_link_pkg;

  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b00,
    SCAN_FIRST = 2'b01,
    SCAN_AGAIN = 2'b10,
    SCAN_REQUEST = 2'b11
  } scan_state_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_READ = 2'b01,
    OP_DISP_A = 2'b10,
    OP_DISP_B = 2'b11
  } frame_op_t;

  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_SHIFT = 2'b01,
    HOST_CLOSE = 2'b10
  } host_state_t;

endpackage : key_link_pkg

// ===== pkg/key_link_if.sv
// Three-wire link plus open-drain request/data return line.
// Assumes a pull-up on the return line: released means high.
`timescale 1ns/1ps
interface key_link_if;
  logic ce;
  logic cl;
  logic di;
  logic do_oe;
  wire do_line;

  // The return line stands in for open drain: do_line is driven to ~do_oe, so it is driven high whenever released.
  assign do_line = ~do_oe;

  modport device (
    input ce,
    input cl,
    input di,
    output do_oe
  );

  modport controller (
    output ce,
    output cl,
    output di,
    input do_line
  );
endinterface : key_link_if

// ===== src/key_scan_device.sv
// Key scanner and display latch end of the serial link.
// Assumes clock_i is the device oscillator (one period is T) and
// that the controller drives ce, cl and di as key_link_if says.
`timescale 1ns/1ps
`include "key_link_defines.svh"
module key_scan_device #(
  parameter int unsigned SCAN_T = `SCAN_AGREED_T
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [`KEY_BITS-1:0] key_lines_i,
  input wire logic sleep_i,
  output logic [`DISP_BITS-1:0] segment_display_bits_o,
  output logic key_request_o,
  key_link_if.device link
);

  generate
    if (SCAN_T < 2 || SCAN_T > 2047) begin : g_bad
      $error("SCAN_T out of range");
    end
  endgenerate

  // ****************************************************************
  // Oscillator domain: synchronisers
  // ****************************************************************
  logic [`KEY_BITS-1:0] keys_meta, keys_s;
  logic ce_meta, ce_s, dl_meta, dl_s, sleep_meta, sleep_s;
  logic rd_meta, rd_s, rd_q, dp_meta, dp_s, dp_q;
  logic rd_tgl, dp_tgl, do_low_link;
  logic [`DISP_BITS-1:0] disp_shadow;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      keys_meta <= '0;
      keys_s <= '0;
      ce_meta <= 1'b0;
      ce_s <= 1'b0;
      dl_meta <= 1'b0;
      dl_s <= 1'b0;
      sleep_meta <= 1'b0;
      sleep_s <= 1'b0;
      {rd_meta, rd_s, rd_q} <= 3'h0;
      {dp_meta, dp_s, dp_q} <= 3'h0;
    end else begin
      keys_meta <= key_lines_i;
      keys_s <= keys_meta;
      ce_meta <= link.ce;
      ce_s <= ce_meta;
      dl_meta <= do_low_link;
      dl_s <= dl_meta;
      sleep_meta <= sleep_i;
      sleep_s <= sleep_meta;
      {rd_meta, rd_s, rd_q} <= {rd_tgl, rd_meta, rd_s};
      {dp_meta, dp_s, dp_q} <= {dp_tgl, dp_meta, dp_s};
    end
  end

  wire read_done = rd_s ^ rd_q;

  // ****************************************************************
  // Oscillator domain: key scan
  // ****************************************************************
  key_link_pkg::scan_state_t state;
  logic [10:0] cnt;
  logic [`KEY_BITS-1:0] sample, key_state;
  logic sleep_state, last_zero;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= key_link_pkg::SCAN_IDLE;
      cnt <= 11'h000;
      sample <= '0;
      key_state <= '0;
      sleep_state <= 1'b0;
      last_zero <= 1'b1;
    end else begin
      unique case (state)
        key_link_pkg::SCAN_IDLE: begin
          if (keys_s != '0 || !last_zero) begin
            sample <= keys_s;
            cnt <= 11'(SCAN_T - 1);
            state <= key_link_pkg::SCAN_FIRST;
          end
        end
        key_link_pkg::SCAN_FIRST: begin
          cnt <= cnt - 11'h001;
          if (cnt == 11'h000) begin
            if (keys_s != sample) begin
              // Scans disagree: one more scan period, 1230 T total.
              sample <= keys_s;
              cnt <= 11'(SCAN_T - 1);
              state <= key_link_pkg::SCAN_AGAIN;
            end else if (keys_s == '0 && last_zero) begin
              state <= key_link_pkg::SCAN_IDLE;
            end else begin
              key_state <= keys_s;
              sleep_state <= sleep_s;
              state <= key_link_pkg::SCAN_REQUEST;
            end
          end
        end
        key_link_pkg::SCAN_AGAIN: begin
          cnt <= cnt - 11'h001;
          if (cnt == 11'h000) begin
            if (keys_s == '0 && last_zero) begin
              state <= key_link_pkg::SCAN_IDLE;
            end else begin
              key_state <= keys_s;
              sleep_state <= sleep_s;
              state <= key_link_pkg::SCAN_REQUEST;
            end
          end
        end
        key_link_pkg::SCAN_REQUEST: begin
          if (read_done) begin
            // Released and rescanned once the data was read.
            last_zero <= (key_state == '0);
            sample <= keys_s;
            cnt <= 11'(SCAN_T - 1);
            state <= key_link_pkg::SCAN_FIRST;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Oscillator domain: pin and user outputs
  // ****************************************************************
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link.do_oe <= 1'b0;
      key_request_o <= 1'b0;
      segment_display_bits_o <= '0;
    end else begin
      key_request_o <= (state == key_link_pkg::SCAN_REQUEST);
      if (ce_s) begin
        link.do_oe <= dl_s;
      end else begin
        link.do_oe <= (state == key_link_pkg::SCAN_REQUEST);
      end
      if (dp_s ^ dp_q) begin
        segment_display_bits_o <= disp_shadow;
      end
    end
  end

  // ****************************************************************
  // Link domain
  // ****************************************************************
  // The frame's own enable clears the frame logic, since the link
  // clock stands still between frames.
  wire frame_rst_n = rst_n_i & link.ce;
  logic req_meta, req_l, valid;
  logic [5:0] bit_cnt;
  logic [`ADDR_BITS-1:0] addr_sh;
  logic [`READ_BITS-1:0] out_sh;
  logic [`DISP_HALF-1:0] disp_in;
  key_link_pkg::frame_op_t op;
  wire [`ADDR_BITS-1:0] addr_now = {link.di, addr_sh[`ADDR_BITS-1:1]};
  wire [`DISP_HALF-1:0] disp_now = {link.di, disp_in[`DISP_HALF-1:1]};
  wire [`READ_BITS-1:0] key_word =
    req_l ? {sleep_state, key_state} : {`READ_BITS{1'b1}};

  always_ff @(posedge link.cl or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_meta <= 1'b0;
      req_l <= 1'b0;
    end else begin
      req_meta <= (state == key_link_pkg::SCAN_REQUEST);
      req_l <= req_meta;
    end
  end

  always_ff @(posedge link.cl or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt <= 6'h00;
      addr_sh <= '0;
      out_sh <= '1;
      op <= key_link_pkg::OP_NONE;
      valid <= 1'b0;
      do_low_link <= 1'b0;
    end else begin
      if (bit_cnt != 6'h3F) begin
        bit_cnt <= bit_cnt + 6'h01;
      end
      if (bit_cnt < 6'(`ADDR_BITS)) begin
        addr_sh <= addr_now;
      end
      if (bit_cnt == 6'(`ADDR_BITS - 1)) begin
        if (addr_now == `KEY_READ_ADDR) begin
          op <= key_link_pkg::OP_READ;
          valid <= req_l;
          out_sh <= key_word;
          do_low_link <= ~key_word[0];
        end else if (addr_now == `DISP_ADDR_A) begin
          op <= key_link_pkg::OP_DISP_A;
        end else if (addr_now == `DISP_ADDR_B) begin
          op <= key_link_pkg::OP_DISP_B;
        end
      end else if (op == key_link_pkg::OP_READ) begin
        out_sh <= {1'b1, out_sh[`READ_BITS-1:1]};
        do_low_link <= ~out_sh[1] & (bit_cnt < 6'(`READ_LAST_EDGE));
      end
    end
  end

  // Kept outside the frame reset so toggles and data survive CE low.
  always_ff @(posedge link.cl or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_tgl <= 1'b0;
      dp_tgl <= 1'b0;
      disp_in <= '0;
      disp_shadow <= '0;
    end else begin
      disp_in <= disp_now;
      // A read while the line was released does not clear the request.
      if (op == key_link_pkg::OP_READ && valid &&
          bit_cnt == 6'(`READ_LAST_EDGE)) begin
        rd_tgl <= ~rd_tgl;
      end
      if (bit_cnt == 6'(`DISP_LAST_EDGE)) begin
        if (op == key_link_pkg::OP_DISP_A) begin
          disp_shadow[`DISP_HALF-1:0] <= disp_now;
        end else if (op == key_link_pkg::OP_DISP_B) begin
          disp_shadow[`DISP_BITS-1:`DISP_HALF] <=
            disp_now[`DISP_BITS-`DISP_HALF-1:0];
          dp_tgl <= ~dp_tgl;
        end
      end
    end
  end

endmodule : key_scan_device

// ===== src/key_link_controller.sv
// Controller end of the serial key and display link.
// Assumes the device end of key_link_if and a pull-up on the
// return line; the link clock is divided down from clock_i.
`timescale 1ns/1ps
`include "key_link_defines.svh"
module key_link_controller #(
  parameter int unsigned HALF_BIT = `HALF_BIT_CYCLES,
  parameter int unsigned POLL = `POLL_CYCLES,
  parameter int unsigned HOLDOFF = `HOLDOFF_CYCLES,
  parameter int unsigned DISP_WINDOW = `DISP_WINDOW_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic irq_mode_i,
  input wire logic disp_req_i,
  input wire logic [`DISP_BITS-1:0] segment_display_bits_i,
  output logic [`KEY_BITS-1:0] key_state_bits_o,
  output logic sleep_ack_bit_o,
  output logic key_valid_o,
  output logic disp_busy_o,
  output logic disp_late_o,
  key_link_if.controller link
);

  localparam int unsigned FRAME_READ = `ADDR_BITS + `READ_BITS;
  localparam int unsigned FRAME_DISP = `ADDR_BITS + `DISP_HALF;
  localparam int unsigned READ_SPAN = 2 * HALF_BIT * (FRAME_READ + 1);

  generate
    // The device needs a few of its own cycles to present each bit.
    if (HALF_BIT < 8 || HALF_BIT > 255) begin : g_bad_half
      $error("HALF_BIT out of range");
    end
    if (POLL <= `RESCAN_HOST_CYCLES + READ_SPAN) begin : g_bad_poll
      $error("POLL too short for rescan plus read");
    end
    if (HOLDOFF <= `RESCAN_HOST_CYCLES) begin : g_bad_hold
      $error("HOLDOFF not above the rescan time");
    end
  endgenerate

  // ****************************************************************
  // Request line synchroniser
  // ****************************************************************
  logic do_meta, do_s;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      do_meta <= 1'b1;
      do_s <= 1'b1;
    end else begin
      do_meta <= link.do_line;
      do_s <= do_meta;
    end
  end

  // ****************************************************************
  // Acquisition timers
  // ****************************************************************
  key_link_pkg::host_state_t state;
  key_link_pkg::frame_op_t op;
  logic [31:0] poll_cnt, hold_cnt, win_cnt;
  logic poll_due, disp_pend, win_run;
  logic [`DISP_BITS-1:0] disp_data;
  wire idle = (state == key_link_pkg::HOST_IDLE);
  wire read_end;
  wire start_read = idle && !do_s &&
    (irq_mode_i ? (hold_cnt == 32'h0) : poll_due);
  wire start_disp = idle && !start_read && disp_pend;

  // Sized for the slowest oscillator, so any device meets it.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      poll_cnt <= 32'h0;
      poll_due <= 1'b0;
    end else begin
      if (poll_cnt == 32'h0) begin
        poll_cnt <= POLL - 1;
      end else begin
        poll_cnt <= poll_cnt - 32'h1;
      end
      // A tick met during a busy frame is held, never skipped.
      if (poll_cnt == 32'h0 && !irq_mode_i) begin
        poll_due <= 1'b1;
      end else if (idle) begin
        poll_due <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_cnt <= 32'h0;
    end else if (read_end) begin
      hold_cnt <= HOLDOFF;
    end else if (hold_cnt != 32'h0) begin
      hold_cnt <= hold_cnt - 32'h1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      disp_pend <= 1'b0;
      disp_data <= '0;
    end else if (disp_req_i && !disp_pend) begin
      disp_pend <= 1'b1;
      disp_data <= segment_display_bits_i;
    end else if (start_disp) begin
      disp_pend <= 1'b0;
    end
  end

  // ****************************************************************
  // Frame engine
  // ****************************************************************
  logic [7:0] phase;
  logic [5:0] bit_idx;
  logic [`ADDR_BITS+`DISP_HALF-1:0] tx_sh;
  logic [`READ_BITS-1:0] rx_sh;
  wire last_bit = (op == key_link_pkg::OP_READ) ?
    (bit_idx == 6'(FRAME_READ - 1)) : (bit_idx == 6'(FRAME_DISP - 1));
  wire close_end = (state == key_link_pkg::HOST_CLOSE) &&
    (phase == 8'(2 * HALF_BIT - 1));
  assign read_end = close_end && (op == key_link_pkg::OP_READ);
  wire [`DISP_HALF-1:0] half_b =
    {1'b0, disp_data[`DISP_BITS-1:`DISP_HALF]};

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= key_link_pkg::HOST_IDLE;
      op <= key_link_pkg::OP_NONE;
      phase <= 8'h00;
      bit_idx <= 6'h00;
      tx_sh <= '0;
      rx_sh <= '0;
      link.ce <= 1'b0;
      link.cl <= 1'b0;
      link.di <= 1'b0;
    end else begin
      unique case (state)
        key_link_pkg::HOST_IDLE: begin
          phase <= 8'h00;
          bit_idx <= 6'h00;
          if (start_read) begin
            op <= key_link_pkg::OP_READ;
            tx_sh <= {{`DISP_HALF{1'b0}}, `KEY_READ_ADDR};
            link.ce <= 1'b1;
            state <= key_link_pkg::HOST_SHIFT;
          end else if (start_disp) begin
            op <= key_link_pkg::OP_DISP_A;
            tx_sh <= {disp_data[`DISP_HALF-1:0], `DISP_ADDR_A};
            link.ce <= 1'b1;
            state <= key_link_pkg::HOST_SHIFT;
          end
        end
        key_link_pkg::HOST_SHIFT: begin
          phase <= phase + 8'h01;
          if (phase == 8'h00) begin
            link.cl <= 1'b0;
            link.di <= tx_sh[0];
          end
          if (phase == 8'(HALF_BIT - 1) &&
              op == key_link_pkg::OP_READ &&
              bit_idx >= 6'(`ADDR_BITS)) begin
            rx_sh <= {do_s, rx_sh[`READ_BITS-1:1]};
          end
          if (phase == 8'(HALF_BIT)) begin
            link.cl <= 1'b1;
          end
          if (phase == 8'(2 * HALF_BIT - 1)) begin
            phase <= 8'h00;
            tx_sh <= tx_sh >> 1;
            bit_idx <= bit_idx + 6'h01;
            if (last_bit) begin
              state <= key_link_pkg::HOST_CLOSE;
            end
          end
        end
        key_link_pkg::HOST_CLOSE: begin
          phase <= phase + 8'h01;
          if (phase == 8'h00) begin
            link.cl <= 1'b0;
            link.di <= 1'b0;
          end
          // Dropping the enable one cycle early leaves a full half bit
          // of quiet before the second display half starts.
          if (phase == 8'(HALF_BIT - 1)) begin
            link.ce <= 1'b0;
          end
          if (close_end) begin
            phase <= 8'h00;
            bit_idx <= 6'h00;
            if (op == key_link_pkg::OP_DISP_A) begin
              // Second half follows at once to stay inside the window.
              op <= key_link_pkg::OP_DISP_B;
              tx_sh <= {half_b, `DISP_ADDR_B};
              link.ce <= 1'b1;
              state <= key_link_pkg::HOST_SHIFT;
            end else begin
              op <= key_link_pkg::OP_NONE;
              state <= key_link_pkg::HOST_IDLE;
            end
          end
        end
        default: begin
          state <= key_link_pkg::HOST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Results and display window watch
  // ****************************************************************
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      key_state_bits_o <= '0;
      sleep_ack_bit_o <= 1'b0;
      key_valid_o <= 1'b0;
    end else begin
      key_valid_o <= read_end;
      if (read_end) begin
        key_state_bits_o <= rx_sh[`KEY_BITS-1:0];
        sleep_ack_bit_o <= rx_sh[`READ_BITS-1];
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      win_cnt <= 32'h0;
      win_run <= 1'b0;
      disp_late_o <= 1'b0;
      disp_busy_o <= 1'b0;
    end else begin
      disp_busy_o <= disp_pend || op == key_link_pkg::OP_DISP_A ||
        op == key_link_pkg::OP_DISP_B;
      if (start_disp) begin
        win_cnt <= DISP_WINDOW - 1;
        win_run <= 1'b1;
        disp_late_o <= 1'b0;
      end else if (win_run) begin
        win_cnt <= win_cnt - 32'h1;
        if (close_end && op == key_link_pkg::OP_DISP_B) begin
          win_run <= 1'b0;
        end else if (win_cnt == 32'h0) begin
          disp_late_o <= 1'b1;
          win_run <= 1'b0;
        end
      end
    end
  end

endmodule : key_link_controller

// ===== test/key_link_sva.sv
// Checker on the key link wires, sampled by the controller clock.
// Assumes instantiation beside key_link_if with its signals as inputs.
`timescale 1ns/1ps
`include "key_link_defines.svh"
module key_link_sva (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce,
  input wire logic cl,
  input wire logic di,
  input wire logic do_oe,
  input wire logic do_line
);
  localparam int WAIT_MAX = 6000;
  logic [5:0] n_bits;
  logic [7:0] addr;
  logic [12:0] wait_cnt;

  // ****************************************************************
  // Frame decode
  // ****************************************************************
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) n_bits <= 6'h00;
    else if (!ce) n_bits <= 6'h00;
    else if ($rose(cl)) n_bits <= n_bits + 6'h01;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) addr <= 8'h00;
    else if (ce && $rose(cl) && n_bits < 6'h08) addr <= {di, addr[7:1]};
  end

  // A request that is never served would otherwise go unseen.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) wait_cnt <= 13'h0000;
    else if (ce || do_line) wait_cnt <= 13'h0000;
    else wait_cnt <= wait_cnt + 13'h0001;
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  idle_clock_a: assert property (!ce |-> !cl)
    else $error("link clock moved outside a frame");
  frame_lead_a: assert property ($rose(ce) |-> !cl [*8] ##[1:2] cl)
    else $error("first link clock rise misplaced");
  clock_high_a: assert property ($rose(cl) |-> cl [*8] ##1 !cl)
    else $error("link clock high phase has wrong length");
  data_hold_a: assert property (cl |-> $stable(di))
    else $error("serial data changed while link clock high");
  frame_gap_a: assert property ($fell(ce) |-> !ce [*8])
    else $error("frames too close together");
  frame_shape_a: assert property ($fell(ce) |->
    (n_bits == 6'h27 && addr == `KEY_READ_ADDR) ||
    (n_bits == 6'h2E && (addr == `DISP_ADDR_A || addr == `DISP_ADDR_B)))
    else $error("frame address or length wrong");
  reply_quiet_a: assert property (ce && n_bits >= 6'h08 &&
    addr != `KEY_READ_ADDR |-> !do_oe)
    else $error("return line pulled during a display frame");
  read_wait_a: assert property (wait_cnt < WAIT_MAX)
    else $error("pending key request left unread");
endmodule : key_link_sva

// ===== test/keypad_data_read_handshake_tb_top.sv
// Bench joining both ends of the key link over one interface.
// Assumes the design and key_link_defines.svh are compiled first.
`timescale 1ns/1ps
`include "key_link_defines.svh"
module keypad_data_read_handshake_tb_top;
  // Controller timing is rescaled for a 32 ns device oscillator.
  localparam int RESCAN = `SCAN_RESCAN_T * 32 / 10;
  localparam int AGREE = `SCAN_AGREED_T * 32 / 10;
  logic clock_i = 1'b0;
  logic dev_clock = 1'b0;
  logic rst_n_i = 1'b0;
  logic irq_mode_i = 1'b0;
  logic disp_req_i = 1'b0;
  logic sleep_i = 1'b0;
  logic [`KEY_BITS-1:0] key_lines_i = '0;
  logic [`DISP_BITS-1:0] seg_in = '0;
  logic [`DISP_BITS-1:0] seg_out;
  logic [`KEY_BITS-1:0] keys_out;
  logic sleep_ack, key_valid, disp_busy, disp_late, key_request;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  key_link_if link ();
  key_scan_device u_key_scan_device (.clock_i(dev_clock),
    .rst_n_i(rst_n_i), .key_lines_i(key_lines_i), .sleep_i(sleep_i),
    .segment_display_bits_o(seg_out), .key_request_o(key_request),
    .link(link));
  key_link_controller #(.POLL(RESCAN + 672), .HOLDOFF(RESCAN + 16),
    .DISP_WINDOW(2000)) u_key_link_controller (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .irq_mode_i(irq_mode_i), .disp_req_i(disp_req_i),
    .segment_display_bits_i(seg_in), .key_state_bits_o(keys_out),
    .sleep_ack_bit_o(sleep_ack), .key_valid_o(key_valid),
    .disp_busy_o(disp_busy), .disp_late_o(disp_late), .link(link));
  key_link_sva u_key_link_sva (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .ce(link.ce), .cl(link.cl), .di(link.di), .do_oe(link.do_oe),
    .do_line(link.do_line));

  initial begin
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    #3.7;
    forever #16 dev_clock = ~dev_clock;
  end
  always @(posedge clock_i) begin
    cycles = cycles + 1;
    if (cycles == 90000) begin
      n_errors = n_errors + 1;
      complete_run();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic check_vec(input logic [`DISP_BITS-1:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_vec

  task automatic check_min(input int got, least);
    checks_done++;
    if (got < least) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, least);
    end
  endtask : check_min

  task automatic step();
    @(posedge clock_i);
    #1;
  endtask : step

  task automatic wait_valid(output int n);
    n = 0;
    do begin
      step();
      n++;
    end while (key_valid !== 1'b1 && n < 15000);
    if (n >= 15000) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, key_valid,
        1'b1);
    end
  endtask : wait_valid

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic release_keys();
    int n;
    key_lines_i = '0;
    wait_valid(n);
    check_vec(keys_out, '0);
    check_vec(sleep_ack, 1'b0);
    repeat (RESCAN) step();
    check_vec(key_request, 1'b0);
  endtask : release_keys

  task automatic show(input logic [`DISP_BITS-1:0] pat);
    int n;
    seg_in = pat;
    disp_req_i = 1'b1;
    step();
    disp_req_i = 1'b0;
    n = 0;
    while (disp_busy !== 1'b1 && n < 4) begin
      step();
      n++;
    end
    while (disp_busy !== 1'b0 && n < 5000) begin
      step();
      n++;
    end
    check_vec(seg_out, pat);
    check_vec(disp_late, 1'b0);
  endtask : show

  task automatic agreed_press();
    int n;
    sleep_i = 1'b1;
    key_lines_i = 30'h2000_0001;
    n = 0;
    while (key_request !== 1'b1 && n < 3000) begin
      step();
      n++;
    end
    check_min(n, AGREE);
    check_min(AGREE + 40, n);
    // A display sent while the request is pending must keep the line quiet.
    show(75'h555_0000_FFFF_1234_5678);
    wait_valid(n);
    check_vec(keys_out, 30'h2000_0001);
    check_vec(sleep_ack, 1'b1);
    sleep_i = 1'b0;
    release_keys();
  endtask : agreed_press

  // The pattern changes mid-scan, so the scanner must look again.
  task automatic changed_press();
    int n;
    key_lines_i = 30'h0000_0300;
    repeat (AGREE / 3) step();
    key_lines_i = 30'h0004_0000;
    wait_valid(n);
    check_vec(keys_out, 30'h0004_0000);
    check_min(n + AGREE / 3, RESCAN);
    release_keys();
  endtask : changed_press

  task automatic held_irq();
    int n;
    int m;
    irq_mode_i = 1'b1;
    key_lines_i = 30'h1555_5555;
    wait_valid(n);
    wait_valid(m);
    check_vec(keys_out, 30'h1555_5555);
    check_min(m, RESCAN + 1);
    release_keys();
    irq_mode_i = 1'b0;
  endtask : held_irq

  initial begin
    repeat (20) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    step();
    check_vec({link.ce, link.cl, link.do_oe, key_valid, disp_busy}, '0);
    show(75'h7FF_FFFF_FFFF_FFFF_FFFF);
    show(75'h2AA_AAAA_AAAA_AAAA_AAA5);
    agreed_press();
    changed_press();
    held_irq();
    complete_run();
  end
endmodule : keypad_data_read_handshake_tb_top
